// ### design/mlpd_core.v
// 24-channel LED PWM driver core with write-only serial slave
// Notes on behaviour
// - Each of 24 outputs has its own 8-bit PWM near 97 kHz.
// - Individual duty runs from 0 at code 0 to 255/256.
// - Group PWM dims at 190 Hz or blinks with programmable period.
// - Each output selects off, on, individual PWM, or individual plus group.
// - Deasserted active-low gate switches all outputs off together.
// - Software reset call restores all defaults like power-on reset.
// - Chase byte enables or disables selected outputs.
// - Outputs update at each acknowledge after the address byte, or at stop; stop is default.
// - Only write transfers accepted at up to 5 MHz; no reads.
// - Six address pins form part of the slave address.
// - Group call and three sub call addresses, each enableable.
// - Individual brightness resets to off, group brightness to maximum.
// - PWM timing derives from the internal clock, no external parts.
// - First byte after address is control: 6-bit pointer, top bit increments.
// - Group call enabled and sub calls disabled at reset.
`timescale 1ns/1ps
`default_nettype none
`include "mlpd_consts.vh"
module mlpd_core (
   // Clock and reset
   input  wire        clk,
   input  wire        srst,
   // Serial bus pins (input only)
   input  wire        fast_serial_clock,
   input  wire        fast_serial_data,
   // Hardware address pins
   input  wire [5:0]  hw_address_in,
   // Output gate, active low
   input  wire        out_gate_n,
   // LED sinks, high turns the sink on
   output reg  [23:0] led_sink_output
);
   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   reg [1:0] scl_s;
   reg [1:0] sda_s;
   reg [1:0] oe_s;
   reg [11:0] hwa_s;
   reg       scl_d;
   reg       sda_d;
   always @(posedge clk) begin
      scl_s <= {scl_s[0], fast_serial_clock};
      sda_s <= {sda_s[0], fast_serial_data};
      oe_s  <= {oe_s[0], out_gate_n};
      hwa_s <= {hwa_s[5:0], hw_address_in};
      scl_d <= scl_s[1];
      sda_d <= sda_s[1];
   end
   wire scl_rise = scl_s[1] & ~scl_d;
   wire start_c  = scl_s[1] & scl_d & sda_d & ~sda_s[1];
   wire stop_c   = scl_s[1] & scl_d & ~sda_d & sda_s[1];
   ////////////////////////////////////////////////////////////////////////////
   // Serial receiver
   localparam [3:0] S_IDLE = 4'h1, S_ADR = 4'h2, S_CTL = 4'h4, S_DAT = 4'h8;
   reg  [3:0]  st_reg;
   reg  [3:0]  bit_reg;
   reg  [7:0]  sh_reg;
   reg  [5:0]  ptr_reg;
   reg         inc_reg;
   reg         swr_reg;
   reg         wr_pulse;
   reg         ack_pulse;
   reg  [5:0]  wr_ptr;
   reg  [7:0]  wr_dat;
   reg         soft_rst;
   // Register file
   reg  [7:0]  mode_reg;
   reg  [7:0]  grp_duty_reg;
   reg  [7:0]  grp_freq_reg;
   reg  [23:0] chase_reg;
   reg  [7:0]  sub1_reg;
   reg  [7:0]  sub2_reg;
   reg  [7:0]  sub3_reg;
   reg  [7:0]  all_reg;
   reg  [7:0]  duty_sh [0:23];
   reg  [1:0]  sel_sh  [0:23];
   reg  [7:0]  duty_act [0:23];
   reg  [1:0]  sel_act  [0:23];
   reg  [23:0] chase_act;
   wire [7:0]  byte_in = {sh_reg[6:0], sda_s[1]};
   wire        rst_all = srst | soft_rst;
   wire [6:0]  hw_adr  = {`MLPD_HW_HI, hwa_s[11:6]};
   wire        adr_hit = (byte_in[7:1] == hw_adr) |
                         (mode_reg[`MLPD_MB_ALL]  & (byte_in[7:1] == all_reg[7:1]))  |
                         (mode_reg[`MLPD_MB_SUB1] & (byte_in[7:1] == sub1_reg[7:1])) |
                         (mode_reg[`MLPD_MB_SUB2] & (byte_in[7:1] == sub2_reg[7:1])) |
                         (mode_reg[`MLPD_MB_SUB3] & (byte_in[7:1] == sub3_reg[7:1]));
   // Bit 8 of each byte is the acknowledge slot; the master drives it high
   always @(posedge clk) begin
      wr_pulse  <= 1'b0;
      ack_pulse <= 1'b0;
      soft_rst  <= 1'b0;
      if (srst) begin
         st_reg  <= S_IDLE;
         bit_reg <= 4'h0;
         sh_reg  <= 8'h00;
         ptr_reg <= 6'h00;
         inc_reg <= 1'b0;
         swr_reg <= 1'b0;
         wr_ptr  <= 6'h00;
         wr_dat  <= 8'h00;
      end else if (start_c) begin
         st_reg  <= S_ADR;
         bit_reg <= 4'h0;
         swr_reg <= 1'b0;
      end else if (stop_c) begin
         st_reg  <= S_IDLE;
      end else if (scl_rise && st_reg != S_IDLE) begin
         if (bit_reg == 4'h8) begin
            bit_reg <= 4'h0;
            ack_pulse <= (st_reg == S_DAT);
         end else begin
            bit_reg <= bit_reg + 4'h1;
            sh_reg  <= byte_in;
            if (bit_reg == 4'h7) begin
               case (st_reg)
                  S_ADR: begin
                     if (byte_in == {`MLPD_RST_CALL_ADR, 1'b0}) begin
                        swr_reg <= 1'b1;
                        st_reg  <= S_CTL;
                     end else if (adr_hit && !byte_in[0])
                        st_reg <= S_CTL;
                     else
                        st_reg <= S_IDLE;
                  end
                  S_CTL: begin
                     if (swr_reg)
                        soft_rst <= 1'b1;
                     ptr_reg <= byte_in[5:0];
                     inc_reg <= byte_in[7];
                     st_reg  <= swr_reg ? S_IDLE : S_DAT;
                  end
                  S_DAT: begin
                     wr_pulse <= 1'b1;
                     wr_ptr   <= ptr_reg;
                     wr_dat   <= byte_in;
                     if (inc_reg)
                        ptr_reg <= (ptr_reg == `MLPD_R_ALL) ? 6'h00 : ptr_reg + 6'h01;
                  end
                  default: st_reg <= S_IDLE;
               endcase
            end
         end
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // Register writes and shadow transfer
   wire upd = mode_reg[`MLPD_MB_ACKUPD] ? ack_pulse : stop_c;
   always @(posedge clk) begin
      if (rst_all) begin
         mode_reg     <= `MLPD_MODE_DEF;
         grp_duty_reg <= `MLPD_GRP_DEF;
         grp_freq_reg <= `MLPD_FREQ_DEF;
         chase_reg    <= `MLPD_CHASE_DEF;
         sub1_reg     <= {`MLPD_SUB1_DEF, 1'b0};
         sub2_reg     <= {`MLPD_SUB2_DEF, 1'b0};
         sub3_reg     <= {`MLPD_SUB3_DEF, 1'b0};
         all_reg      <= {`MLPD_ALL_DEF, 1'b0};
         chase_act    <= `MLPD_CHASE_DEF;
      end else begin
         if (wr_pulse) begin
            case (wr_ptr)
               `MLPD_R_MODE:    mode_reg     <= wr_dat;
               `MLPD_R_GRPPWM:  grp_duty_reg <= wr_dat;
               `MLPD_R_GRPFREQ: grp_freq_reg <= wr_dat;
               `MLPD_R_CHASE:   chase_reg    <= {3{wr_dat}};
               `MLPD_R_SUB1:    sub1_reg     <= wr_dat;
               `MLPD_R_SUB2:    sub2_reg     <= wr_dat;
               `MLPD_R_SUB3:    sub3_reg     <= wr_dat;
               `MLPD_R_ALL:     all_reg      <= wr_dat;
               default: ;
            endcase
         end
         if (upd)
            chase_act <= chase_reg;
      end
   end
   genvar g;
   generate
      for (g = 0; g < `MLPD_NCH; g = g + 1) begin : g_ch
         always @(posedge clk) begin
            if (rst_all) begin
               duty_sh[g]  <= `MLPD_DUTY_DEF;
               sel_sh[g]   <= `MLPD_M_OFF;
               duty_act[g] <= `MLPD_DUTY_DEF;
               sel_act[g]  <= `MLPD_M_OFF;
            end else begin
               if (wr_pulse && wr_ptr == `MLPD_R_PWM0 + g)
                  duty_sh[g] <= wr_dat;
               if (wr_pulse && wr_ptr == `MLPD_R_SEL0 + g / 4)
                  sel_sh[g] <= wr_dat[2*(g%4)+1 -: 2];
               if (upd) begin
                  duty_act[g] <= duty_sh[g];
                  sel_act[g]  <= sel_sh[g];
               end
            end
         end
      end
   endgenerate
   ////////////////////////////////////////////////////////////////////////////
   // PWM timebases from the core clock
   reg [2:0]  ind_pre;
   reg [7:0]  ind_cnt;
   reg [11:0] grp_pre;
   reg [31:0] blk_pre;
   reg [7:0]  grp_cnt;
   // Blink step period: (freq+1) times the fastest 24 Hz step
   wire [31:0] blk_lim = `MLPD_BLK_MIN * ({24'h000000, grp_freq_reg} + 32'h1);
   wire        blink   = mode_reg[`MLPD_MB_BLINK];
   wire        grp_tick = blink ? (blk_pre >= blk_lim - 32'h1)
                                : (grp_pre == `MLPD_GRP_DIV - 12'd1);
   always @(posedge clk) begin
      if (rst_all) begin
         ind_pre <= 3'h0;
         ind_cnt <= 8'h00;
         grp_pre <= 12'h000;
         blk_pre <= 32'h0;
         grp_cnt <= 8'h00;
      end else begin
         ind_pre <= (ind_pre == `MLPD_IND_DIV - 1) ? 3'h0 : ind_pre + 3'h1;
         if (ind_pre == `MLPD_IND_DIV - 1)
            ind_cnt <= ind_cnt + 8'h01;
         grp_pre <= grp_tick ? 12'h000 : grp_pre + 12'h001;
         blk_pre <= grp_tick ? 32'h0 : blk_pre + 32'h1;
         if (grp_tick)
            grp_cnt <= grp_cnt + 8'h01;
      end
   end
   wire grp_on = grp_cnt < grp_duty_reg;
   ////////////////////////////////////////////////////////////////////////////
   // Output mux, gated by pin and chase mask
   // One register for all sinks keeps the output vector single-driven
   wire [23:0] lvl_vec;
   generate
      for (g = 0; g < `MLPD_NCH; g = g + 1) begin : g_out
         wire ind_on = ind_cnt < duty_act[g];
         reg  lvl;
         always @* begin
            case (sel_act[g])
               `MLPD_M_OFF: lvl = 1'b0;
               `MLPD_M_ON:  lvl = 1'b1;
               `MLPD_M_IND: lvl = ind_on;
               `MLPD_M_GRP: lvl = ind_on & grp_on;
               default:     lvl = 1'b0;
            endcase
         end
         assign lvl_vec[g] = lvl;
      end
   endgenerate
   always @(posedge clk) begin
      if (rst_all)
         led_sink_output <= 24'h000000;
      else
         led_sink_output <= lvl_vec & {24{~oe_s[1]}} & chase_act;
   end
endmodule // mlpd_core
`default_nettype wire

// ### design/mlpd_consts.vh
// Constants for the 24-channel LED PWM driver core
`ifndef MLPD_CONSTS_VH
`define MLPD_CONSTS_VH
`define MLPD_NCH          24
`define MLPD_W8           8
`define MLPD_CLK_HZ       125000000
// 97 kHz individual PWM: 256 steps; step divider from 125 MHz
`define MLPD_IND_HZ       97000
`define MLPD_IND_DIV      5
// Group dimming 190 Hz: 256 steps
`define MLPD_GRP_HZ       190
`define MLPD_GRP_DIV      12'd2570
// Blink step for 24 Hz; 256 frequency codes stretch it to 10.73 s at 125 MHz
`define MLPD_BLK_W        32
`define MLPD_BLK_MIN      32'h00004FF2
// Channel modes
`define MLPD_M_OFF        2'h0
`define MLPD_M_ON         2'h1
`define MLPD_M_IND        2'h2
`define MLPD_M_GRP        2'h3
// Addresses
`define MLPD_RST_CALL_ADR 7'h03
`define MLPD_ALL_DEF      7'h70
`define MLPD_SUB1_DEF     7'h71
`define MLPD_SUB2_DEF     7'h72
`define MLPD_SUB3_DEF     7'h74
`define MLPD_HW_HI        1'h1
// Register pointer map
`define MLPD_R_MODE       6'h00
`define MLPD_R_GRPPWM     6'h01
`define MLPD_R_GRPFREQ    6'h02
`define MLPD_R_CHASE      6'h03
`define MLPD_R_PWM0       6'h04
`define MLPD_R_SEL0       6'h1C
`define MLPD_R_SUB1       6'h22
`define MLPD_R_SUB2       6'h23
`define MLPD_R_SUB3       6'h24
`define MLPD_R_ALL        6'h25
// Mode register bits
`define MLPD_MB_BLINK     0
`define MLPD_MB_ACKUPD    1
`define MLPD_MB_SUB3      2
`define MLPD_MB_SUB2      3
`define MLPD_MB_SUB1      4
`define MLPD_MB_ALL       5
`define MLPD_MODE_DEF     8'h20
`define MLPD_GRP_DEF      8'hFF
`define MLPD_FREQ_DEF     8'h00
`define MLPD_DUTY_DEF     8'h00
`define MLPD_CHASE_DEF    24'hFFFFFF
`endif

// ### testbench/mlpd_core_assertions.sv
// Concurrent checks on the LED driver core pins
`timescale 1ns/1ps
`default_nettype none
module mlpd_core_assertions (
   // Clock and reset
   input wire logic        clk,
   input wire logic        srst,
   // Watched pins
   input wire logic        out_gate_n,
   input wire logic [23:0] led_sink_output
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   // Nothing selected after reset, and no frame can finish this early
   a_reset_dark: assert property ($fell(srst) |-> (led_sink_output == 24'h000000) [*8])
      else $error("outputs lit soon after reset");
   // Gate path is two sync stages plus one register
   a_gate_dark: assert property (out_gate_n [*5] |-> led_sink_output == 24'h000000)
      else $error("outputs lit while gated");
   a_gate_no_rise: assert property (out_gate_n [*5] |->
      (led_sink_output & ~$past(led_sink_output)) == 24'h000000)
      else $error("output rose while gated");
   // Reset must darken the sinks on the very next edge, so no disable here
   a_srst_dark: assert property (disable iff (1'b0) srst |=>
      led_sink_output == 24'h000000)
      else $error("outputs lit after reset");
   // Gate reaches the sinks in exactly three edges
   a_gate_latency: assert property ($rose(out_gate_n) ##1 out_gate_n [*3] |->
      led_sink_output == 24'h000000)
      else $error("gate too slow to darken outputs");
   a_lit_needs_gate: assert property ((led_sink_output != 24'h000000) |->
      !$past(out_gate_n, 3))
      else $error("output lit although gate was closed");
endmodule // mlpd_core_assertions
`default_nettype wire

// ### testbench/mlpd_bus_master.sv
// Write-only serial bus master model
`timescale 1ns/1ps
`default_nettype none
module mlpd_bus_master (
   // Bus lines, driven high by the model when idle
   output var logic scl,
   output var logic sda
);
   initial begin
      scl = 1'b1;
      sda = 1'b1;
   end
   task automatic start_c();
      #3 sda = 1'b0;
      #32 scl = 1'b0;
      #16;
   endtask
   task automatic put_byte(input logic [7:0] b);
      for (int i = 8; i >= 0; i--) begin
         sda = (i == 0) ? 1'b1 : b[i-1];
         #16 scl = 1'b1;
         #32 scl = 1'b0;
         #16;
      end
   endtask
   task automatic stop_c();
      sda = 1'b0;
      #16 scl = 1'b1;
      #32 sda = 1'b1;
      #32;
   endtask
endmodule // mlpd_bus_master
`default_nettype wire

// ### testbench/mlpd_core_tb.sv
// Self-checking bench for the LED driver core
`timescale 1ns/1ps
`default_nettype none
`include "mlpd_consts.vh"
module mlpd_core_tb;
   typedef struct {string nm; bit k; logic [23:0] v;} mlpd_note_t;
   logic        clk = 1'b0;
   logic        srst = 1'b1;
   logic        out_gate_n = 1'b0;
   logic [5:0]  hw_address_in = 6'h2A;
   wire         scl;
   wire         sda;
   wire [23:0]  led_sink_output;
   logic [23:0] c;
   logic [7:0]  r;
   logic [7:0]  dv;
   logic [7:0]  bad [3] = '{8'hD6, 8'hD5, 8'hE2};
   mlpd_note_t  notes [$];
   int          failures = 0;
   int          total_checks = 0;
   always #4 clk = ~clk;
   mlpd_core i_dut (.clk(clk), .srst(srst), .fast_serial_clock(scl), .fast_serial_data(sda),
      .hw_address_in(hw_address_in), .out_gate_n(out_gate_n), .led_sink_output(led_sink_output));
   mlpd_bus_master i_mst (.scl(scl), .sda(sda));
   ////////////////////////////////////////////////////////////
   task automatic report_and_stop();
      $display("checks %0d, failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic cmp_led(input string nm, input logic [23:0] e, input logic [23:0] o);
      total_checks++;
      if (o !== e) begin
         failures++;
         $display("[ERR] %s expected %h seen %h", nm, e, o);
      end
   endtask
   task automatic cmp_cnt(input string nm, input logic [23:0] e, input logic [23:0] o);
      total_checks++;
      if (o !== e) begin
         failures++;
         $display("[ERR] %s expected %0d seen %0d", nm, e, o);
      end
   endtask
   // Driver blocks until the watcher has judged the note
   task automatic exp(input string nm, input bit k, input logic [23:0] v);
      notes.push_back('{nm, k, v});
      wait (notes.size() == 0);
   endtask
   task automatic wr(input logic [7:0] a, input logic [5:0] p, input logic [7:0] d, input bit s);
      i_mst.start_c();
      i_mst.put_byte(a);
      i_mst.put_byte({2'b00, p});
      i_mst.put_byte(d);
      if (s) i_mst.stop_c();
      repeat (10) @(posedge clk);
      #1;
   endtask
   ////////////////////////////////////////////////////////////
   // Count mode measures one full individual period on output 0
   initial forever begin
      wait (notes.size() > 0);
      c = 24'h000000;
      if (notes[0].k) begin
         repeat (256 * `MLPD_IND_DIV) begin
            @(posedge clk);
            #1;
            c = c + led_sink_output[0];
         end
         cmp_cnt(notes[0].nm, notes[0].v, c);
      end else begin
         cmp_led(notes[0].nm, notes[0].v, led_sink_output);
      end
      void'(notes.pop_front());
   end
   initial begin
      #200000;
      failures++;
      report_and_stop();
   end
   initial begin
      void'($urandom(52372));
      r = 8'($urandom);
      dv = 8'($urandom);
      repeat (20) @(posedge clk);
      #1 srst = 1'b0;
      repeat (2) @(posedge clk);
      #1;
      exp("led", 0, 24'h000000);
      i_mst.start_c();
      i_mst.put_byte(8'hD4);
      i_mst.put_byte({2'b10, `MLPD_R_SEL0});
      repeat (6) i_mst.put_byte(8'h55);
      exp("led", 0, 24'h000000);
      i_mst.stop_c();
      repeat (10) @(posedge clk);
      #1;
      exp("led", 0, 24'hFFFFFF);
      wr(8'hD4, `MLPD_R_CHASE, r, 1);
      exp("led", 0, {3{r}});
      out_gate_n = 1'b1;
      repeat (6) @(posedge clk);
      #1;
      exp("led", 0, 24'h000000);
      out_gate_n = 1'b0;
      foreach (bad[i]) begin
         wr(bad[i], `MLPD_R_CHASE, 8'h00, 1);
         exp("led", 0, {3{r}});
      end
      wr({`MLPD_ALL_DEF, 1'b0}, `MLPD_R_CHASE, 8'hFF, 1);
      exp("led", 0, 24'hFFFFFF);
      wr({`MLPD_ALL_DEF, 1'b0}, `MLPD_R_MODE, 8'h30, 1);
      wr({`MLPD_SUB1_DEF, 1'b0}, `MLPD_R_CHASE, 8'h3C, 1);
      exp("led", 0, 24'h3C3C3C);
      wr({`MLPD_ALL_DEF, 1'b0}, `MLPD_R_MODE, 8'h22, 1);
      wr(8'hD4, `MLPD_R_CHASE, 8'h0F, 0);
      exp("led", 0, 24'h0F0F0F);
      i_mst.stop_c();
      wr(8'hD4, `MLPD_R_SEL0, 8'h02, 1);
      for (int j = 0; j < 2; j++) begin
         if (j == 1) dv = 8'hFF;
         wr(8'hD4, `MLPD_R_PWM0, dv, 1);
         exp("pwm", 1, 24'(dv * `MLPD_IND_DIV));
      end
      wr(8'hD4, `MLPD_R_SEL0, 8'h03, 1);
      exp("pwm", 1, 24'(8'hFF * `MLPD_IND_DIV));
      wr(8'hD4, `MLPD_R_GRPPWM, 8'h00, 1);
      exp("pwm", 1, 24'h000000);
      i_mst.start_c();
      i_mst.put_byte(8'h06);
      i_mst.put_byte(8'h00);
      i_mst.stop_c();
      repeat (10) @(posedge clk);
      #1;
      exp("pwm", 1, 24'h000000);
      report_and_stop();
   end
endmodule // mlpd_core_tb
bind mlpd_core mlpd_core_assertions i_chk (.clk(clk), .srst(srst), .out_gate_n(out_gate_n),
   .led_sink_output(led_sink_output));
`default_nettype wire
